// ---- rtl/tbam_band.sv ----
module tbam_band
    import tbam_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    tbam_meas_if.band_cmp meas
);

    typedef struct packed
    {
        logic [BAND_N-1:0] band;
        logic under;
        logic over;
    } tbam_band_st_t;

    tbam_band_st_t s_q;
    tbam_band_st_t s_d;
    logic found;

    // The top band also takes a reading equal to its upper threshold.
    function automatic logic in_band(input logic [TEMP_W-1:0] t, input logic [TEMP_W-1:0] lo,
                                     input logic [TEMP_W-1:0] hi, input logic top);
        return (t >= lo) && ((t < hi) || (top && t == hi));
    endfunction

    always_comb
    begin
        s_d = s_q;
        found = 1'b0;
        s_d.band = '0;
        for (int i = 0; i < BAND_N; i++)
        begin
            if (!found && in_band(meas.temp, meas.thr[i], meas.thr[i+1], i == BAND_N - 1))
            begin
                s_d.band[i] = 1'b1;
                found = 1'b1;
            end
        end
        s_d.under = meas.temp < meas.thr[0];
        s_d.over = meas.temp > meas.thr[THR_N-1];
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign meas.band = s_q.band;
    assign meas.under = s_q.under;
    assign meas.over = s_q.over;

endmodule

// ---- rtl/tbam_meas_if.sv ----
interface tbam_meas_if;
    import tbam_pkg::*;

    logic [TEMP_W-1:0] temp;
    logic raw_low;
    logic raw_high;
    logic [THR_N-1:0][TEMP_W-1:0] thr;
    logic [BAND_N-1:0] band;
    logic under;
    logic over;

    modport scale
    (
        output temp,
        output raw_low,
        output raw_high
    );

    modport band_cmp
    (
        input temp,
        input thr,
        output band,
        output under,
        output over
    );

    modport top
    (
        input temp,
        input raw_low,
        input raw_high,
        output thr,
        input band,
        input under,
        input over
    );

endinterface

// ---- rtl/tbam_pkg.sv ----
package tbam_pkg;

    // Temperatures are carried in hundredths of a degree Celsius.
    localparam int TEMP_W = 16;
    localparam int THR_N = 8;
    localparam int BAND_N = 7;
    localparam int STAMP_W = 48;
    localparam int THR_IN_W = 17;

    localparam logic [15:0] SPAN_LO_CDEG = 16'h03E8;
    localparam logic [15:0] SPAN_HI_CDEG = 16'h2710;
    localparam logic [15:0] SPAN_DIFF_CDEG = 16'h2328;

    // A code of zero is the bottom of the span; full scale is two to this power.
    localparam int ADC_FULL_SHIFT = 14;

    localparam logic [THR_N-1:0][TEMP_W-1:0] THR_RESET = {
        16'h2328, 16'h1F40, 16'h1B58, 16'h1770,
        16'h1388, 16'h0FA0, 16'h0BB8, 16'h07D0
    };

    // Threshold entry arrives in thousandths of a degree.
    localparam logic [THR_IN_W-1:0] THR_ROUND_ADD = 17'h00005;
    localparam logic [THR_IN_W-1:0] THR_ROUND_DIV = 17'h0000A;

    localparam int CLK_PERIOD_NS = 10;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BLINK_CNT_W = 26;

    typedef enum logic [1:0]
    {
        ALM_IDLE = 2'b00,
        ALM_LATCHED = 2'b01,
        ALM_ACKED = 2'b11
    } tbam_alm_t;

    function automatic logic [TEMP_W-1:0] tbam_round_cdeg(input logic [THR_IN_W-1:0] milli);
        logic [THR_IN_W-1:0] q;
        q = (milli + THR_ROUND_ADD) / THR_ROUND_DIV;
        return q[TEMP_W-1:0];
    endfunction

endpackage

// ---- rtl/tbam_scale.sv ----
module tbam_scale
    import tbam_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cap_en_i,
    input wire logic [15:0] adc_code_i,
    tbam_meas_if.scale meas
);

    typedef struct packed
    {
        logic [TEMP_W-1:0] temp;
        logic raw_low;
        logic raw_high;
    } tbam_scale_st_t;

    tbam_scale_st_t s_q;
    tbam_scale_st_t s_d;
    logic signed [31:0] scaled;

    always_comb
    begin
        s_d = s_q;
        scaled = (32'($signed(adc_code_i)) * $signed({16'h0000, SPAN_DIFF_CDEG})) >>> ADC_FULL_SHIFT;
        scaled = scaled + $signed({16'h0000, SPAN_LO_CDEG});
        if (cap_en_i)
        begin
            s_d.raw_low = scaled < $signed({16'h0000, SPAN_LO_CDEG});
            s_d.raw_high = scaled > $signed({16'h0000, SPAN_HI_CDEG});
            if (s_d.raw_low)
                s_d.temp = SPAN_LO_CDEG;
            else if (s_d.raw_high)
                s_d.temp = SPAN_HI_CDEG;
            else
                s_d.temp = scaled[TEMP_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_q <= '{temp: SPAN_LO_CDEG, default: '0};
        else
            s_q <= s_d;
    end

    assign meas.temp = s_q.temp;
    assign meas.raw_low = s_q.raw_low;
    assign meas.raw_high = s_q.raw_high;

endmodule

// ---- rtl/tbam_top.sv ----
// Notes on behaviour
// - Temperature is converted and updated only while capture enable is high.
// - With capture enable low the last recorded temperature is held.
// - Readings beyond the span show as the span's lower or upper limit.
// - Violation when reading is below threshold one or above threshold eight.
// - Latched violation clears only once back in range and acknowledged.
// - Acknowledge acts on a rising edge; panel acknowledge does the same.
// - Each entered threshold is rounded to hundredths before storing.
// - Seven one-hot band outputs mark the pair enclosing the reading.
// - Combined alarm blinks while a violation is latched; it stops once back in range and acknowledged.
// - Under-temperature output is high while reading is below threshold one.
// - Over-temperature output is high while reading is above threshold eight.
// - Keep time of last under event, else the restart time.
// - Keep time of last over event, else the restart time.
module tbam_top
    import tbam_pkg::*;
#(
    parameter int BLINK_HALF_CYC_P = tbam_pkg::BLINK_HALF_CYC
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cap_en_i,
    input wire logic [15:0] adc_code_i,
    input wire logic ack_i,
    input wire logic panel_ack_i,
    input wire logic thr_wr_i,
    input wire logic [2:0] thr_idx_i,
    input wire logic [tbam_pkg::THR_IN_W-1:0] thr_val_i,
    input wire logic [2:0] thr_rd_idx_i,
    input wire logic [tbam_pkg::STAMP_W-1:0] time_now_i,
    output logic [tbam_pkg::TEMP_W-1:0] temp_o,
    output logic raw_low_o,
    output logic raw_high_o,
    output logic [tbam_pkg::BAND_N-1:0] band_o,
    output logic under_o,
    output logic over_o,
    output logic under_lat_o,
    output logic over_lat_o,
    output logic alarm_o,
    output logic [tbam_pkg::TEMP_W-1:0] thr_rd_o,
    output logic thr_order_ok_o,
    output logic [tbam_pkg::STAMP_W-1:0] stamp_under_o,
    output logic [tbam_pkg::STAMP_W-1:0] stamp_over_o
);
    import tbam_pkg::*;

    localparam logic [BLINK_CNT_W-1:0] BLINK_LAST = BLINK_CNT_W'(BLINK_HALF_CYC_P - 1);

    typedef struct packed
    {
        logic [THR_N-1:0][TEMP_W-1:0] threshold_store;
        logic [TEMP_W-1:0] thr_rd;
        logic order_ok;
        logic ack_prev;
        logic panel_prev;
        tbam_alm_t alm;
        logic under_lat;
        logic over_lat;
        logic under_prev;
        logic over_prev;
        logic started;
        logic [BLINK_CNT_W-1:0] blink_cnt;
        logic blink;
        logic [STAMP_W-1:0] stamp_under;
        logic [STAMP_W-1:0] stamp_over;
    } tbam_top_st_t;

    localparam tbam_top_st_t TOP_RESET = '{
        threshold_store: THR_RESET,
        order_ok: 1'b1,
        alm: ALM_IDLE,
        default: '0
    };

    logic rst_meta_q;
    logic rst_sync_q;
    tbam_top_st_t s_q;
    tbam_top_st_t s_d;
    logic ack_edge;
    logic viol;
    logic new_event;
    logic under_event;
    logic over_event;

    // Edge detection is shared by both acknowledge inputs and both violation flags.
    function automatic logic tbam_rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction

    tbam_meas_if meas();

    // The release is synchronised so all flops fed by rst_sync_q leave reset on the same edge.
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    tbam_scale u_scale
    (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_sync_q),
        .cap_en_i(cap_en_i),
        .adc_code_i(adc_code_i),
        .meas(meas.scale)
    );

    tbam_band u_band
    (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_sync_q),
        .meas(meas.band_cmp)
    );

    assign meas.thr = s_q.threshold_store;

    always_comb
    begin
        s_d = s_q;
        ack_edge = tbam_rise(ack_i, s_q.ack_prev) | tbam_rise(panel_ack_i, s_q.panel_prev);
        s_d.ack_prev = ack_i;
        s_d.panel_prev = panel_ack_i;

        viol = meas.under | meas.over;
        under_event = tbam_rise(meas.under, s_q.under_prev);
        over_event = tbam_rise(meas.over, s_q.over_prev);
        new_event = under_event | over_event;
        s_d.under_prev = meas.under;
        s_d.over_prev = meas.over;

        if (thr_wr_i)
        begin
            s_d.threshold_store[thr_idx_i] = tbam_round_cdeg(thr_val_i);
        end
        s_d.thr_rd = s_q.threshold_store[thr_rd_idx_i];

        s_d.order_ok = 1'b1;
        for (int i = 0; i < THR_N - 1; i++)
        begin
            if (s_q.threshold_store[i] >= s_q.threshold_store[i+1])
            begin
                s_d.order_ok = 1'b0;
            end
        end

        // Sticky flags; a live violation always wins over a clear below.
        if (meas.under)
        begin
            s_d.under_lat = 1'b1;
        end
        if (meas.over)
        begin
            s_d.over_lat = 1'b1;
        end

        case (s_q.alm)
            ALM_IDLE:
            begin
                if (viol)
                begin
                    s_d.alm = ALM_LATCHED;
                end
            end
            ALM_LATCHED:
            begin
                if (ack_edge)
                begin
                    s_d.alm = viol ? ALM_ACKED : ALM_IDLE;
                end
            end
            ALM_ACKED:
            begin
                if (new_event)
                begin
                    s_d.alm = ALM_LATCHED;
                end
                else if (!viol)
                begin
                    s_d.alm = ALM_IDLE;
                end
            end
            default:
            begin
                s_d.alm = ALM_IDLE;
            end
        endcase

        if (s_d.alm == ALM_IDLE && !viol)
        begin
            s_d.under_lat = 1'b0;
            s_d.over_lat = 1'b0;
        end

        if (s_d.alm == ALM_IDLE)
        begin
            s_d.blink_cnt = '0;
            s_d.blink = 1'b0;
        end
        else if (s_q.alm == ALM_IDLE)
        begin
            // Light at once so a short violation is never missed by the lamp.
            s_d.blink_cnt = '0;
            s_d.blink = 1'b1;
        end
        else if (s_q.blink_cnt == BLINK_LAST)
        begin
            s_d.blink_cnt = '0;
            s_d.blink = ~s_q.blink;
        end
        else
        begin
            s_d.blink_cnt = s_q.blink_cnt + 1'b1;
        end

        if (!s_q.started || under_event)
        begin
            s_d.stamp_under = time_now_i;
        end
        if (!s_q.started || over_event)
        begin
            s_d.stamp_over = time_now_i;
        end
        s_d.started = 1'b1;
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            s_q <= TOP_RESET;
        else
            s_q <= s_d;
    end

    assign temp_o = meas.temp;
    assign raw_low_o = meas.raw_low;
    assign raw_high_o = meas.raw_high;
    assign band_o = meas.band;
    assign under_o = meas.under;
    assign over_o = meas.over;
    assign under_lat_o = s_q.under_lat;
    assign over_lat_o = s_q.over_lat;
    assign alarm_o = s_q.blink;
    assign thr_rd_o = s_q.thr_rd;
    assign thr_order_ok_o = s_q.order_ok;
    assign stamp_under_o = s_q.stamp_under;
    assign stamp_over_o = s_q.stamp_over;

endmodule

// ---- verification/tbam_top_asserts.sv ----
module tbam_chk
    import tbam_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cap_en_i,
    input wire logic [15:0] adc_code_i,
    input wire logic [STAMP_W-1:0] time_now_i,
    input wire logic [TEMP_W-1:0] temp_o,
    input wire logic [BAND_N-1:0] band_o,
    input wire logic under_o,
    input wire logic over_o,
    input wire logic under_lat_o,
    input wire logic alarm_o,
    input wire logic [STAMP_W-1:0] stamp_under_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Five dark cycles exceed the half period, so the alarm was idle.
    sequence s_quiet;
        (!alarm_o)[*5];
    endsequence
    sequence s_lit;
        s_quiet ##1 ($rose(under_lat_o) && alarm_o);
    endsequence
    a_hold_temp: assert property (!cap_en_i |=> $stable(temp_o))
        else $error("temperature moved without capture");
    a_mid_scale: assert property (cap_en_i && adc_code_i == 16'h2000 |=> temp_o == 16'h157C)
        else $error("mid scale reading wrong");
    a_low_clamp: assert property (cap_en_i && $signed(adc_code_i) < 0 |=> temp_o == SPAN_LO_CDEG)
        else $error("low reading not saturated");
    a_high_clamp: assert property (cap_en_i && $signed(adc_code_i) > 16384 |=> temp_o == SPAN_HI_CDEG)
        else $error("high reading not saturated");
    a_band_onehot: assert property ($onehot0(band_o) && !((under_o || over_o) && band_o != '0))
        else $error("band outputs not one-hot");
    a_under_latch: assert property (under_o |=> under_lat_o)
        else $error("under violation not latched");
    a_clear_range: assert property ($fell(under_lat_o) |-> !$past(under_o))
        else $error("latch cleared while violating");
    a_blink_half: assert property (s_lit ##1 (alarm_o && under_lat_o)[*3] ##1 under_lat_o |-> !alarm_o)
        else $error("alarm blink period wrong");
    a_stamp_under: assert property ($rose(under_o) |=> stamp_under_o == $past(time_now_i))
        else $error("under stamp not taken");
endmodule

bind tbam_top tbam_chk i_chk (.sys_clk_i, .rst_n_i, .cap_en_i, .adc_code_i, .time_now_i, .temp_o, .band_o,
    .under_o, .over_o, .under_lat_o, .alarm_o, .stamp_under_o);

// ---- verification/tbam_xducer_model.sv ----
// Transducer side: hands the requested code to the device one falling edge later.
module tbam_xducer_model
(
    input wire logic clk_i,
    input wire logic [15:0] code_i,
    output logic [15:0] adc_code_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Codes beyond span.
    // Codes beyond the span are passed unclamped, so saturation is the device's job.
    always @(negedge clk_i)
        adc_code_o <= code_i;
endmodule

// ---- verification/test_temperature_band_alarm_monitor.sv ----
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, a); end end
module test_temperature_band_alarm_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    import tbam_pkg::*;
    logic sys_clk_i = 0, rst_n_i = 0, cap_en_i = 0, ack_i = 0, panel_ack_i = 0, thr_wr_i = 0;
    logic [2:0] thr_idx_i = 0, thr_rd_idx_i = 0;
    logic [THR_IN_W-1:0] thr_val_i = 0;
    logic [STAMP_W-1:0] time_now_i = 48'h00000000A5A5;
    logic [15:0] code_req = 0, lfsr = 16'h0041, adc_code_i;
    logic [TEMP_W-1:0] temp_o, thr_rd_o;
    logic [BAND_N-1:0] band_o;
    logic raw_low_o, raw_high_o, under_o, over_o, under_lat_o, over_lat_o, alarm_o, thr_order_ok_o;
    logic [STAMP_W-1:0] stamp_under_o, stamp_over_o;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    logic signed [15:0] corner [4] = '{16'sh0000, 16'sh4000, -16'sh0001, 16'sh4001};

    tbam_xducer_model i_xducer (.clk_i(sys_clk_i), .code_i(code_req), .adc_code_o(adc_code_i));
    tbam_top #(.BLINK_HALF_CYC_P(4)) i_dut (.sys_clk_i, .rst_n_i, .cap_en_i, .adc_code_i, .ack_i, .panel_ack_i,
        .thr_wr_i, .thr_idx_i, .thr_val_i, .thr_rd_idx_i, .time_now_i, .temp_o, .raw_low_o, .raw_high_o, .band_o,
        .under_o, .over_o, .under_lat_o, .over_lat_o, .alarm_o, .thr_rd_o, .thr_order_ok_o, .stamp_under_o,
        .stamp_over_o);

    initial
    begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [15:0] exp_temp(input logic signed [15:0] c);
        int t;
        t = 1000 + ((int'(c) * 9000) >>> 14);
        return (t < 1000) ? 16'h03E8 : (t > 10000) ? 16'h2710 : t[15:0];
    endfunction

    function automatic logic [6:0] exp_band(input logic [15:0] t);
        logic [6:0] b;
        b = '0;
        for (int i = 0; i < 7; i++)
            b[i] = (t >= 2000 + 1000 * i) && (t < 3000 + 1000 * i || (i == 6 && t == 9000));
        return b;
    endfunction

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    task automatic meas(input logic signed [15:0] c);
        logic [15:0] t;
        t = exp_temp(c);
        code_req <= c;
        step(1);
        cap_en_i <= 1;
        step(1);
        cap_en_i <= 0;
        code_req <= ~c;
        step(3);
        `CHK("temp", t, temp_o)
        `CHK("band", exp_band(t), band_o)
        `CHK("under", t < 16'h07D0, under_o)
        `CHK("over", t > 16'h2328, over_o)
        `CHK("raw_low", ((int'(c) * 9000) >>> 14) < 0, raw_low_o)
        `CHK("raw_high", ((int'(c) * 9000) >>> 14) > 9000, raw_high_o)
        step(2);
        `CHK("held", t, temp_o)
    endtask

    task automatic wr(input logic [2:0] idx, input logic [16:0] v);
        thr_wr_i <= 1;
        thr_idx_i <= idx;
        thr_val_i <= v;
        thr_rd_idx_i <= idx;
        step(1);
        thr_wr_i <= 0;
        step(3);
    endtask

    task automatic ack(input logic panel);
        ack_i <= !panel;
        panel_ack_i <= panel;
        step(1);
        ack_i <= 0;
        panel_ack_i <= 0;
        step(2);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // The ceiling is more than ten times the length of the full sequence.
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    initial
    begin
        step(5);
        rst_n_i <= 1;
        step(4);
        `CHK("stamp_under", 48'hA5A5, stamp_under_o)
        `CHK("stamp_over", 48'hA5A5, stamp_over_o)
        for (int i = 0; i < 8; i++)
        begin
            thr_rd_idx_i <= i[2:0];
            step(2);
            `CHK("thr", 16'(2000 + 1000 * i), thr_rd_o)
        end
        wr(3'h0, 17'd25004);
        `CHK("round_down", 16'h09C4, thr_rd_o)
        wr(3'h0, 17'd25005);
        `CHK("round_up", 16'h09C5, thr_rd_o)
        wr(3'h0, 17'd35000);
        `CHK("order_bad", 1'b0, thr_order_ok_o)
        wr(3'h0, 17'd20000);
        `CHK("order_ok", 1'b1, thr_order_ok_o)
        foreach (corner[i])
            meas(corner[i]);
        meas(16'sh2000);
        for (int i = 0; i < 30; i++)
        begin
            lfsr = lfsr_next(lfsr);
            meas(16'(lfsr % 19000) - 16'sd1300);
        end
        meas(16'sh2000);
        ack(1'b0);
        step(6);
        time_now_i <= 48'h777;
        meas(16'sh0000);
        `CHK("under_lat", 1'b1, under_lat_o)
        `CHK("stamp_new", 48'h777, stamp_under_o)
        meas(16'sh2000);
        `CHK("lat_no_ack", 1'b1, under_lat_o)
        ack(1'b0);
        `CHK("lat_acked", 1'b0, under_lat_o)
        `CHK("alarm_off", 1'b0, alarm_o)
        time_now_i <= 48'h999;
        meas(16'sh4000);
        `CHK("stamp_over", 48'h999, stamp_over_o)
        ack(1'b1);
        `CHK("over_still", 1'b1, over_lat_o)
        meas(16'sh0000);
        meas(16'sh2000);
        `CHK("relatch", 1'b1, under_lat_o)
        ack(1'b0);
        meas(16'sh2000);
        `CHK("over_clear", 1'b0, over_lat_o)
        `CHK("alarm_done", 1'b0, alarm_o)
        complete_run();
    end
endmodule
